/* File: src/chgs_pkg.sv */
// Purpose: shared constants for the charger setpoint and mask register bank
// Assumes: byte-wide registers reached over a two-wire serial target port
// Notes:   offsets are register addresses on the serial bus
package chgs_pkg;
  localparam logic [7:0] FLAG_TIMERS_ADDR = 8'h03;
  localparam logic [7:0] MASK_TIMERS_ADDR = 8'h0a;
  localparam logic [7:0] BAT_VREG_ADDR    = 8'h12;
  localparam logic [7:0] FAST_CHG_ADDR    = 8'h13;
  localparam logic [7:0] PRE_CHG_ADDR     = 8'h14;
  localparam logic [7:0] TERM_CTRL_ADDR   = 8'h15;

  localparam logic [7:0] MASK_TIMERS_RST  = 8'h00;
  localparam logic [7:0] BAT_VREG_RST     = 8'h3c;
  localparam logic [7:0] FAST_CHG_RST     = 8'h08;
  localparam logic [7:0] PRE_CHG_RST      = 8'h02;
  localparam logic [7:0] TERM_CTRL_RST    = 8'h14;
  localparam logic [7:0] FLAG_RST         = 8'h00;

  localparam int WDOG_BIT       = 6;
  localparam int SAFETY_BIT     = 5;
  localparam int REG_OCP_BIT    = 4;
  localparam int WAKE1_BIT      = 2;
  localparam int WAKE2_BIT      = 1;
  localparam int RST_WARN_BIT   = 0;
  localparam int STEP_SEL_BIT   = 7;
  localparam logic [7:0] EVENT_BITS = 8'h77;
  localparam logic [6:0] VREG_CODE_MAX = 7'h64;
  localparam int VREG_FIELD_W   = 7;
  localparam int PRE_FIELD_W    = 5;

  localparam int VREG_BASE_MV   = 3600;
  localparam int VREG_STEP_MV   = 10;
  localparam int STEP_FINE_UA   = 1250;
  localparam int STEP_COARSE_UA = 2500;
  localparam int VOLT_W         = 13;
  localparam int CURR_W         = 20;

  localparam logic [6:0] TARGET_ADDR_DEF = 7'h5a;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_ACKA   = 3'b010,
    ST_WRITE  = 3'b011,
    ST_ACKW   = 3'b100,
    ST_READ   = 3'b101,
    ST_ACKR   = 3'b110
  } chgs_state_t;
endpackage

/* File: src/chgs_sync2.sv */
// Purpose: two-flop synchroniser for a pin level
// Assumes: din is asynchronous to core_clk
// Notes:   the first stage feeds only the second
`timescale 1ns/10ps
module chgs_sync2 (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic clkEn,
  input  wire logic din,
  output logic      dout
);
  logic stage1;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= 1'b1;
      dout   <= 1'b1;
    end else if (clkEn) begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule // chgs_sync2

/* File: src/chgs_setpoint.sv */
// Purpose: turns setpoint codes into physical targets for the analog loops
// Assumes: codes come from registers on the same clock
// Notes:   results are registered, one cycle behind the codes
`timescale 1ns/10ps
module chgs_setpoint
  import chgs_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  input  wire logic                clkEn,
  input  wire logic [6:0]          vregCode,
  input  wire logic [7:0]          fastCode,
  input  wire logic [4:0]          preCode,
  input  wire logic                stepSel,
  output logic      [VOLT_W-1:0]   batteryTargetMv,
  output logic      [CURR_W-1:0]   fastChargeUa,
  output logic      [CURR_W-1:0]   prechargeUa
);
  function automatic logic [CURR_W-1:0] toUa(input logic [7:0] code,
                                             input logic sel);
    int step;
    step = sel ? STEP_COARSE_UA : STEP_FINE_UA;
    return CURR_W'(int'(code) * step);
  endfunction

  wire logic [VOLT_W-1:0] next_mv = VOLT_W'(VREG_BASE_MV + int'(vregCode) * VREG_STEP_MV);
  wire logic [CURR_W-1:0] next_fast = toUa(fastCode, stepSel);
  wire logic [CURR_W-1:0] next_pre  = toUa({3'h0, preCode}, stepSel);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      batteryTargetMv <= '0;
      fastChargeUa    <= '0;
      prechargeUa     <= '0;
    end else if (clkEn) begin
      batteryTargetMv <= next_mv;
      fastChargeUa    <= next_fast;
      prechargeUa     <= next_pre;
    end
  end
endmodule // chgs_setpoint

/* File: src/chgs_regs_top.sv */
// Purpose: serial-bus register bank for charger setpoints, timer/fault masks
// Assumes: event inputs are one-cycle pulses on core_clk; scl/sda are pins
// Notes:   pointer auto-increments on each data byte, read or write
// Behaviour
// - mask bit 6 gates watchdog fault interrupt
// - mask bit 5 gates safety timer interrupt
// - mask bit 4 gates regulator overcurrent interrupt
// - mask bits 2,1 gate button wake timers
// - mask bit 0 gates button reset warning
// - mask register at 0xa resets to zero
// - battery target 3.6 V plus 10 mV steps
// - codes above 4.6 V saturate at 4.6 V
// - regulation register resets to 0x3c
// - fast current is code times chosen step
// - fast current register at 0x13 resets 0x08
// - pre-charge bit 7 picks current step
// - pre-charge current is code times step
// - pre-charge register resets to 0x02
// - termination register at 0x15 resets 0x14
// - event flags latch, clear on host read
`timescale 1ns/10ps
module chgs_regs_top
  import chgs_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_DEF
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  input  wire logic                    clkEn,
  input  wire logic                    sclIn,
  input  wire logic                    sdaIn,
  output logic                         sdaOut,
  output logic                         sdaOe,
  input  wire logic                    watchdogEvent,
  input  wire logic                    safetyTimerEvent,
  input  wire logic                    regOvercurrentEvent,
  input  wire logic                    wakeFirstEvent,
  input  wire logic                    wakeSecondEvent,
  input  wire logic                    resetWarnEvent,
  output logic                         irqReq,
  output logic [7:0]                   interrupt_mask_timers_faults,
  output logic [7:0]                   termination_control,
  output logic                         current_step_select,
  output logic [chgs_pkg::VOLT_W-1:0]  batteryTargetMv,
  output logic [chgs_pkg::CURR_W-1:0]  fastChargeUa,
  output logic [chgs_pkg::CURR_W-1:0]  prechargeUa
);
  logic        sclS;
  logic        sdaS;
  logic        sclPrev;
  logic        sdaPrev;
  chgs_state_t state;
  logic [3:0]  bitCnt;
  logic [7:0]  shiftIn;
  logic [7:0]  txByte;
  logic [7:0]  regPtr;
  logic        readDir;
  logic        firstByte;
  logic        hostNack;
  logic        wrStb;
  logic        rdStb;
  logic [7:0]  rdAddr;
  logic [7:0]  battery_regulation_voltage;
  logic [7:0]  fast_charge_current;
  logic [7:0]  precharge_current_and_step;
  logic [7:0]  eventFlags;

  chgs_sync2 u_scl_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .clkEn    (clkEn),
    .din      (sclIn),
    .dout     (sclS)
  );

  chgs_sync2 u_sda_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .clkEn    (clkEn),
    .din      (sdaIn),
    .dout     (sdaS)
  );

  // bus conditions, seen on the synchronised lines
  wire logic sclRise = sclS & ~sclPrev;
  wire logic sclFall = ~sclS & sclPrev;
  wire logic startCond = sclS & sclPrev & sdaPrev & ~sdaS;
  wire logic stopCond = sclS & sclPrev & ~sdaPrev & sdaS;
  wire logic byteDone = (bitCnt == 4'h8);
  wire logic addrHit = (shiftIn[7:1] == TARGET_ADDR);

  function automatic logic [7:0] readMux(input logic [7:0] a,
                                         input logic [7:0] m,
                                         input logic [7:0] v,
                                         input logic [7:0] f,
                                         input logic [7:0] p,
                                         input logic [7:0] t,
                                         input logic [7:0] fl);
    case (a)
      FLAG_TIMERS_ADDR: return fl;
      MASK_TIMERS_ADDR: return m;
      BAT_VREG_ADDR:    return v;
      FAST_CHG_ADDR:    return f;
      PRE_CHG_ADDR:     return p;
      TERM_CTRL_ADDR:   return t;
      default:          return 8'h00;
    endcase
  endfunction

  wire logic [7:0] rdData = readMux(regPtr, interrupt_mask_timers_faults,
                                    battery_regulation_voltage, fast_charge_current,
                                    precharge_current_and_step, termination_control,
                                    eventFlags);

  // serial target engine: address, write pointer/data, read with host ack
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclPrev   <= 1'b1;
      sdaPrev   <= 1'b1;
      state     <= ST_IDLE;
      bitCnt    <= 4'h0;
      shiftIn   <= 8'h00;
      txByte    <= 8'h00;
      regPtr    <= 8'h00;
      readDir   <= 1'b0;
      firstByte <= 1'b0;
      hostNack  <= 1'b0;
      sdaOe     <= 1'b0;
      wrStb     <= 1'b0;
      rdStb     <= 1'b0;
      rdAddr    <= 8'h00;
    end else if (clkEn) begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
      wrStb   <= 1'b0;
      rdStb   <= 1'b0;
      if (startCond) begin
        state  <= ST_ADDR;
        bitCnt <= 4'h0;
        sdaOe  <= 1'b0;
      end else if (stopCond) begin
        state <= ST_IDLE;
        sdaOe <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sdaOe <= 1'b0;
          end
          ST_ADDR, ST_WRITE: begin
            if (sclRise && !byteDone) begin
              shiftIn <= {shiftIn[6:0], sdaS};
              bitCnt  <= bitCnt + 4'h1;
            end else if (sclFall && byteDone) begin
              if (state == ST_ADDR) begin
                if (addrHit) begin
                  readDir <= shiftIn[0];
                  state   <= ST_ACKA;
                  sdaOe   <= 1'b1;
                end else begin
                  state <= ST_IDLE;
                end
              end else begin
                if (firstByte) begin
                  regPtr <= shiftIn;
                end else begin
                  wrStb  <= 1'b1;
                  regPtr <= regPtr + 8'h01;
                end
                rdAddr <= regPtr;
                state  <= ST_ACKW;
                sdaOe  <= 1'b1;
              end
            end
          end
          ST_ACKA, ST_ACKW: begin
            if (sclFall) begin
              bitCnt    <= 4'h0;
              firstByte <= (state == ST_ACKA);
              if (state == ST_ACKA && readDir) begin
                state  <= ST_READ;
                txByte <= rdData;
                rdAddr <= regPtr;
                rdStb  <= 1'b1;
                regPtr <= regPtr + 8'h01;
                sdaOe  <= ~rdData[7];
                bitCnt <= 4'h1;
              end else begin
                state <= ST_WRITE;
                sdaOe <= 1'b0;
              end
            end
          end
          ST_READ: begin
            if (sclFall) begin
              if (byteDone) begin
                sdaOe <= 1'b0;
                state <= ST_ACKR;
              end else begin
                sdaOe  <= ~txByte[3'(4'h7 - bitCnt)];
                bitCnt <= bitCnt + 4'h1;
              end
            end
          end
          ST_ACKR: begin
            if (sclRise) begin
              hostNack <= sdaS;
            end else if (sclFall) begin
              if (hostNack) begin
                state <= ST_IDLE;
              end else begin
                state  <= ST_READ;
                txByte <= rdData;
                rdAddr <= regPtr;
                rdStb  <= 1'b1;
                regPtr <= regPtr + 8'h01;
                sdaOe  <= ~rdData[7];
                bitCnt <= 4'h1;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end

  // open-drain: only ever pulls low
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sdaOut <= 1'b0;
    end else if (clkEn) begin
      sdaOut <= 1'b0;
    end
  end

  // register writes; whole bytes stored, reserved bits included, battery code clamped at 0x64
  wire logic wrMask = wrStb && (rdAddr == MASK_TIMERS_ADDR);
  wire logic wrVreg = wrStb && (rdAddr == BAT_VREG_ADDR);
  wire logic wrFast = wrStb && (rdAddr == FAST_CHG_ADDR);
  wire logic wrPre  = wrStb && (rdAddr == PRE_CHG_ADDR);
  wire logic wrTerm = wrStb && (rdAddr == TERM_CTRL_ADDR);
  wire logic vregOver = shiftIn[6:0] > VREG_CODE_MAX;
  wire logic [7:0] next_vreg = {shiftIn[7], vregOver ? VREG_CODE_MAX : shiftIn[6:0]};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      interrupt_mask_timers_faults <= MASK_TIMERS_RST;
      battery_regulation_voltage   <= BAT_VREG_RST;
      fast_charge_current          <= FAST_CHG_RST;
      precharge_current_and_step   <= PRE_CHG_RST;
      termination_control          <= TERM_CTRL_RST;
    end else if (clkEn) begin
      if (wrMask) interrupt_mask_timers_faults <= shiftIn;
      if (wrVreg) battery_regulation_voltage <= next_vreg;
      if (wrFast) fast_charge_current <= shiftIn;
      if (wrPre) precharge_current_and_step <= shiftIn;
      if (wrTerm) termination_control <= shiftIn;
    end
  end

  // event flags: set wins over the read clear
  wire logic [7:0] eventIn = {1'b0,
                              watchdogEvent,
                              safetyTimerEvent,
                              regOvercurrentEvent,
                              1'b0,
                              wakeFirstEvent,
                              wakeSecondEvent,
                              resetWarnEvent};
  wire logic flagRead = rdStb && (rdAddr == FLAG_TIMERS_ADDR);
  wire logic [7:0] next_flags = (eventIn | (flagRead ? 8'h00 : eventFlags)) & EVENT_BITS;

  // masked flags still latch; only unmasked ones raise the request
  wire logic [7:0] liveFlags = eventFlags & ~interrupt_mask_timers_faults & EVENT_BITS;
  wire logic wdogIrq   = liveFlags[WDOG_BIT];
  wire logic safetyIrq = liveFlags[SAFETY_BIT];
  wire logic ocpIrq    = liveFlags[REG_OCP_BIT];
  wire logic wakeIrq   = liveFlags[WAKE1_BIT] | liveFlags[WAKE2_BIT];
  wire logic warnIrq   = liveFlags[RST_WARN_BIT];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      eventFlags <= FLAG_RST;
      irqReq     <= 1'b0;
    end else if (clkEn) begin
      eventFlags <= next_flags;
      irqReq     <= wdogIrq | safetyIrq | ocpIrq | wakeIrq | warnIrq;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      current_step_select <= PRE_CHG_RST[STEP_SEL_BIT];
    end else if (clkEn) begin
      current_step_select <= precharge_current_and_step[STEP_SEL_BIT];
    end
  end

  chgs_setpoint u_setpoint (
    .core_clk        (core_clk),
    .rst_b           (rst_b),
    .clkEn           (clkEn),
    .vregCode        (battery_regulation_voltage[VREG_FIELD_W-1:0]),
    .fastCode        (fast_charge_current),
    .preCode         (precharge_current_and_step[PRE_FIELD_W-1:0]),
    .stepSel         (precharge_current_and_step[STEP_SEL_BIT]),
    .batteryTargetMv (batteryTargetMv),
    .fastChargeUa    (fastChargeUa),
    .prechargeUa     (prechargeUa)
  );
endmodule // chgs_regs_top

/* File: sim/chgs_regs_chk.sv */
// Purpose: port-level assertions for the charger register bank
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every chgs_regs_top instance
`timescale 1ns/10ps
module chgs_regs_chk
  import chgs_pkg::*;
(
  input wire logic                        core_clk,
  input wire logic                        rst_b,
  input wire logic                        clkEn,
  input wire logic                        sclIn,
  input wire logic                        watchdogEvent,
  input wire logic                        safetyTimerEvent,
  input wire logic                        regOvercurrentEvent,
  input wire logic                        wakeFirstEvent,
  input wire logic                        wakeSecondEvent,
  input wire logic                        resetWarnEvent,
  input wire logic                        irqReq,
  input wire logic [7:0]                  interrupt_mask_timers_faults,
  input wire logic [7:0]                  termination_control,
  input wire logic                        current_step_select,
  input wire logic [chgs_pkg::VOLT_W-1:0] batteryTargetMv,
  input wire logic [chgs_pkg::CURR_W-1:0] fastChargeUa,
  input wire logic [chgs_pkg::CURR_W-1:0] prechargeUa
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire logic [7:0]  evtVec = {1'b0, watchdogEvent, safetyTimerEvent, regOvercurrentEvent,
                              1'b0, wakeFirstEvent, wakeSecondEvent, resetWarnEvent};
  wire logic [31:0] stepUa = current_step_select ? 32'd2500 : 32'd1250;
  // an event that its mask lets through, then the request
  sequence openEvt_s;
    clkEn && |(evtVec & ~interrupt_mask_timers_faults);
  endsequence
  sequence irqUp_s;
    ##[1:3] irqReq;
  endsequence
  reset_vals_a: assert property (!$past(rst_b) |->
    interrupt_mask_timers_faults == 8'h00 && termination_control == 8'h14
    && !current_step_select && !irqReq) else $error("bad value after reset");
  irq_masked_a: assert property (($past(interrupt_mask_timers_faults) | ~EVENT_BITS)
    == 8'hff |-> !irqReq) else $error("request while all masked");
  irq_event_a: assert property (openEvt_s |-> irqUp_s)
    else $error("unmasked event gave no request");
  vreg_range_a: assert property ($past(rst_b) |-> batteryTargetMv >= 3600
    && batteryTargetMv <= 4600 && (batteryTargetMv - 3600) % 10 == 0)
    else $error("battery target off grid");
  fast_step_a: assert property ($past(rst_b) |-> fastChargeUa % stepUa == 0
    && fastChargeUa <= 255 * stepUa) else $error("fast current off step");
  pre_step_a: assert property ($past(rst_b) |-> prechargeUa % stepUa == 0
    && prechargeUa <= 31 * stepUa) else $error("precharge current off step");
  mask_write_a: assert property ($changed(interrupt_mask_timers_faults) |-> !sclIn)
    else $error("mask changed outside a write");
  term_write_a: assert property ($changed(termination_control) |-> !sclIn)
    else $error("termination changed outside a write");
endmodule // chgs_regs_chk

bind chgs_regs_top chgs_regs_chk u_chk (.core_clk, .rst_b, .clkEn, .sclIn, .watchdogEvent,
  .safetyTimerEvent, .regOvercurrentEvent, .wakeFirstEvent, .wakeSecondEvent,
  .resetWarnEvent, .irqReq, .interrupt_mask_timers_faults, .termination_control,
  .current_step_select, .batteryTargetMv, .fastChargeUa, .prechargeUa);

/* File: sim/chgs_host_model.sv */
// Purpose: behavioural serial-bus host that reads and writes the bank
// Assumes: SDA has a pull-up; the device only pulls it low
// Notes:   counts address, pointer and data bytes the device failed to acknowledge
`timescale 1ns/10ps
module chgs_host_model
  import chgs_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sdaOe,
  output logic      scl,
  output wire logic sda
);
  logic sdaDrv;
  int   missedAck;
  assign sda = sdaDrv & ~sdaOe;
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
    missedAck = 0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic bitx(input logic b, output logic r);
    sdaDrv = b;
    wt(3);
    scl = 1'b1;
    wt(5);
    r = sda;
    scl = 1'b0;
    wt(3);
  endtask
  task automatic start();
    sdaDrv = 1'b1;
    wt(3);
    scl = 1'b1;
    wt(4);
    sdaDrv = 1'b0;
    wt(4);
    scl = 1'b0;
    wt(3);
  endtask
  task automatic stop();
    sdaDrv = 1'b0;
    wt(3);
    scl = 1'b1;
    wt(4);
    sdaDrv = 1'b1;
    wt(4);
  endtask
  // the host always releases the ninth bit: it sees the device ack on
  // writes and addresses, and gives the nack that ends a read when rd is set
  task automatic xbyte(input logic [7:0] d, input logic rd, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(1'b1, a);
    if (!rd && a) missedAck++;
  endtask
  task automatic wrReg(input logic [7:0] p, input logic [7:0] v);
    logic [7:0] j;
    start();
    xbyte({TARGET_ADDR_DEF, 1'b0}, 1'b0, j);
    xbyte(p, 1'b0, j);
    xbyte(v, 1'b0, j);
    stop();
  endtask
  task automatic rdReg(input logic [7:0] p, output logic [7:0] q);
    logic [7:0] j;
    start();
    xbyte({TARGET_ADDR_DEF, 1'b0}, 1'b0, j);
    xbyte(p, 1'b0, j);
    start();
    xbyte({TARGET_ADDR_DEF, 1'b1}, 1'b0, j);
    xbyte(8'hff, 1'b1, q);
    stop();
  endtask
endmodule // chgs_host_model

/* File: sim/test_chgs_regs_top.sv */
// Purpose: self-checking bench for the charger register bank
// Assumes: the host model drives the serial pins
// Notes:   random values come from a fixed seed
`timescale 1ns/10ps
module test_chgs_regs_top;
  import chgs_pkg::*;
  logic              core_clk;
  logic              rst_b;
  logic              runEn;
  logic [7:0]        evt;
  wire logic         sclIn;
  wire logic         sdaIn;
  logic              sdaOut, sdaOe, irqReq, step;
  logic [7:0]        mask, term, q, v, f, p, t;
  logic [VOLT_W-1:0] mv;
  logic [CURR_W-1:0] fUa, pUa;
  int                num_errors, samples_checked, seed, cyc;
  int                pos [6]    = '{6, 5, 4, 2, 1, 0};
  logic [7:0]        adrTab [5] = '{8'h0a, 8'h12, 8'h13, 8'h14, 8'h15};
  logic [7:0]        rstTab [5] = '{8'h00, 8'h3c, 8'h08, 8'h02, 8'h14};
  logic [7:0]        vTab [5]   = '{8'h64, 8'h65, 8'h7f, 8'he4, 8'h80};
  chgs_regs_top DUT (.core_clk, .rst_b, .clkEn(runEn), .sclIn, .sdaIn, .sdaOut, .sdaOe,
    .watchdogEvent(evt[6]), .safetyTimerEvent(evt[5]), .regOvercurrentEvent(evt[4]),
    .wakeFirstEvent(evt[2]), .wakeSecondEvent(evt[1]), .resetWarnEvent(evt[0]), .irqReq,
    .interrupt_mask_timers_faults(mask), .termination_control(term),
    .current_step_select(step), .batteryTargetMv(mv), .fastChargeUa(fUa),
    .prechargeUa(pUa));
  chgs_host_model u_host (.core_clk, .sdaOe, .scl(sclIn), .sda(sdaIn));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic chkReg(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkOut(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] expV(input logic [7:0] d);
    return {d[7], (d[6:0] > 7'd100) ? 7'd100 : d[6:0]};
  endfunction
  function automatic logic [31:0] expUa(input logic [7:0] c, input logic s);
    return c * (s ? 32'd2500 : 32'd1250);
  endfunction
  task automatic pulse(input int b);
    evt = 8'h01 << b;
    u_host.wt(1);
    evt = 8'h00;
    u_host.wt(3);
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    rst_b = 1'b0;
    evt = 8'h00;
    runEn = 1'b1;
    seed = 21608;
    num_errors = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (10) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    u_host.wt(4);
    for (int i = 0; i < 5; i++) begin
      u_host.rdReg(adrTab[i], q);
      chkReg(q, rstTab[i]);
    end
    chkOut(32'(mv), 32'd4200);
    chkOut(32'(fUa), 32'd10000);
    chkOut(32'(pUa), 32'd2500);
    // battery code: boundaries first, then random
    for (int i = 0; i < 9; i++) begin
      v = (i < 5) ? vTab[i] : 8'($random(seed));
      u_host.wrReg(BAT_VREG_ADDR, v);
      u_host.wt(3);
      chkOut(32'(mv), 32'd3600 + 32'(expV(v) & 8'h7f) * 32'd10);
      u_host.rdReg(BAT_VREG_ADDR, q);
      chkReg(q, expV(v));
    end
    // currents under both steps, termination byte
    for (int i = 0; i < 4; i++) begin
      f = 8'($random(seed));
      p = 8'($random(seed));
      t = 8'($random(seed));
      p[7] = i[0];
      u_host.wrReg(FAST_CHG_ADDR, f);
      u_host.wrReg(PRE_CHG_ADDR, p);
      u_host.wrReg(TERM_CTRL_ADDR, t);
      u_host.wt(3);
      chkOut(32'(fUa), expUa(f, p[7]));
      chkOut(32'(pUa), expUa({3'b000, p[4:0]}, p[7]));
      chkReg({7'd0, step}, {7'd0, p[7]});
      chkReg(term, t);
      u_host.rdReg(FAST_CHG_ADDR, q);
      chkReg(q, f);
      u_host.rdReg(PRE_CHG_ADDR, q);
      chkReg(q, p);
    end
    // each event masked, then alone let through
    for (int i = 0; i < 6; i++) begin
      u_host.wrReg(MASK_TIMERS_ADDR, 8'hff);
      pulse(pos[i]);
      chkReg({7'd0, irqReq}, 8'h00);
      u_host.rdReg(FLAG_TIMERS_ADDR, q);
      chkReg(q, 8'h01 << pos[i]);
      u_host.rdReg(FLAG_TIMERS_ADDR, q);
      chkReg(q, 8'h00);
      u_host.wrReg(MASK_TIMERS_ADDR, ~(8'h01 << pos[i]));
      pulse(pos[i]);
      chkReg({7'd0, irqReq}, 8'h01);
      u_host.rdReg(MASK_TIMERS_ADDR, q);
      chkReg(q, ~(8'h01 << pos[i]));
      u_host.rdReg(FLAG_TIMERS_ADDR, q);
      u_host.wt(3);
      chkReg({7'd0, irqReq}, 8'h00);
    end
    // events while the clock enable is low must leave no trace
    u_host.wrReg(MASK_TIMERS_ADDR, 8'h00);
    runEn = 1'b0;
    evt = 8'($random(seed)) | 8'h40;
    u_host.wt(2);
    evt = 8'h00;
    u_host.wt(2);
    runEn = 1'b1;
    u_host.wt(3);
    chkReg({7'd0, irqReq}, 8'h00);
    u_host.rdReg(FLAG_TIMERS_ADDR, q);
    chkReg(q, 8'h00);
    // unmapped place reads zero
    u_host.wrReg(8'h20, 8'ha5);
    u_host.rdReg(8'h20, q);
    chkReg(q, 8'h00);
    rst_b = 1'b0;
    u_host.wt(2);
    rst_b = 1'b1;
    u_host.wt(3);
    chkReg(mask, 8'h00);
    chkReg(term, 8'h14);
    chkOut(32'(mv), 32'd4200);
    u_host.rdReg(PRE_CHG_ADDR, q);
    chkReg(q, 8'h02);
    chkOut(32'(u_host.missedAck), 32'd0);
    chkReg({7'd0, sdaOut}, 8'h00);
    end_of_test();
  end
endmodule // test_chgs_regs_top
